//--- psc_pkg.sv
// Purpose: shared constants and types of the configuration register bank
// Assumes: 16-bit data, 22-bit word address, 256-word rows
// Notes: bus config field positions follow the register layout
package psc_pkg;

  // ==========================================
  // widths and addresses
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int COL_W = 8;
  localparam logic [ADDR_W-1:0] TOP_ADDR = 22'h3fffff;
  localparam logic [COL_W-1:0] COL_LAST = 8'hff;

  // ==========================================
  // register values
  localparam logic [DATA_W-1:0] BUS_RESET = 16'h9d1f;
  localparam logic [DATA_W-1:0] REF_RESET = 16'h0010;
  // arbitrary value
  localparam logic [DATA_W-1:0] ID_VALUE = 16'h0a5a;

  // ==========================================
  // register select
  localparam int SEL_HI = 19;
  localparam int SEL_LO = 18;
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_ID = 2'h1;
  localparam logic [1:0] SEL_BUS = 2'h2;
  localparam logic [DATA_W-1:0] SW_REF = 16'h0000;
  localparam logic [DATA_W-1:0] SW_BUS = 16'h0001;
  localparam logic [DATA_W-1:0] SW_ID = 16'h0002;

  // ==========================================
  // bus configuration fields
  localparam int B_MODE = 15;
  localparam int B_FIXED = 14;
  localparam int B_LAT_HI = 13;
  localparam int B_LAT_LO = 11;
  localparam int B_WPOL = 10;
  localparam int B_WCFG = 8;
  localparam int B_DRV_HI = 5;
  localparam int B_DRV_LO = 4;
  localparam int B_NOWRAP = 3;
  localparam int B_LEN_HI = 2;
  localparam int B_LEN_LO = 0;
  localparam logic [2:0] LEN_4 = 3'h1;
  localparam logic [2:0] LEN_8 = 3'h2;
  localparam logic [2:0] LEN_16 = 3'h3;
  localparam logic [2:0] LEN_32 = 3'h4;
  localparam logic [4:0] MASK_4 = 5'h03;
  localparam logic [4:0] MASK_8 = 5'h07;
  localparam logic [4:0] MASK_16 = 5'h0f;
  localparam logic [4:0] MASK_32 = 5'h1f;

  // ==========================================
  // types
  typedef enum logic [3:0] {
    SQ_IDLE = 4'h1,
    SQ_RD1 = 4'h2,
    SQ_RD2 = 4'h4,
    SQ_WR3 = 4'h8
  } psc_seq_e;

  typedef struct packed {
    logic regen;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic avalid_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } psc_pins_s;

endpackage

//--- psc_burst_if.sv
// Purpose: carries burst control between the link logic and the address stepper
// Assumes: all signals on the link clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface psc_burst_if;
  logic start;
  logic step;
  logic nowrap;
  logic [2:0] len_code;
  logic [7:0] start_col;
  logic [7:0] col;
  logic active;
  logic row_end;
  modport gen (input start, step, nowrap, len_code, start_col, output col, active, row_end);
  modport user (output start, step, nowrap, len_code, start_col, input col, active, row_end);
endinterface
`default_nettype wire

//--- psc_burst_gen.sv
// Purpose: burst column sequencer for wrap, fixed length and continuous bursts
// Assumes: runs on the link clock with its own synchronised reset
// Notes: reserved length codes run as continuous
`timescale 1ns/1ps
`default_nettype none
module psc_burst_gen import psc_pkg::*; (
  input wire logic lclk,
  input wire logic lrstn,
  psc_burst_if.gen bif
);

  typedef struct packed {
    logic [COL_W-1:0] col;
    logic [4:0] left;
    logic act;
  } psc_bg_s;

  psc_bg_s s_q;
  psc_bg_s s_d;
  logic fixed;
  logic wrap;
  logic [4:0] mask;
  logic [COL_W-1:0] mcol;
  logic [COL_W-1:0] inc;

  // ==========================================
  // length decode
  always_comb begin
    fixed = 1'b1;
    unique case (bif.len_code)
      LEN_4: mask = MASK_4;
      LEN_8: mask = MASK_8;
      LEN_16: mask = MASK_16;
      LEN_32: mask = MASK_32;
      default: begin
        mask = MASK_32;
        fixed = 1'b0;
      end
    endcase
  end

  assign mcol = {3'h0, mask};
  assign inc = s_q.col + 8'h01;
  assign wrap = fixed && !bif.nowrap;

  // ==========================================
  // stepping, same for read and write bursts
  always_comb begin
    s_d = s_q;
    if (bif.start) begin
      s_d.col = bif.start_col;
      s_d.left = mask;
      s_d.act = 1'b1;
    end else if (bif.step && s_q.act) begin
      if (wrap) begin
        s_d.col = (s_q.col & ~mcol) | (inc & mcol);
      end else begin
        s_d.col = inc;
      end
      s_d.left = s_q.left - 5'h01;
      if (fixed && s_q.left == 5'h00) begin
        s_d.act = 1'b0;
      end
      if (!wrap && s_q.col == COL_LAST) begin
        s_d.act = 1'b0;
      end
    end
    if (!lrstn) begin
      s_d = '0;
    end
  end

  always_ff @(posedge lclk) begin
    s_q <= s_d;
  end

  assign bif.col = s_q.col;
  assign bif.active = s_q.act;
  assign bif.row_end = s_q.act && !wrap && s_q.col == COL_LAST;

  a_wrap_block: assert property (@(posedge lclk) disable iff (!lrstn)
    (bif.step && s_q.act && wrap && !bif.start)
    |=> ((s_q.col & ~$past(mcol)) == ($past(s_q.col) & ~$past(mcol))))
    else $error("wrapped burst left its aligned block");

  a_row_stop: assert property (@(posedge lclk) disable iff (!lrstn)
    (bif.step && s_q.act && !wrap && s_q.col == COL_LAST && !bif.start) |=> !s_q.act)
    else $error("burst went past the row end");

endmodule
`default_nettype wire

//--- psc_cfg_regs.sv
// Purpose: configuration register access by pin and software sequence,
//   bus configuration fields, wait shaping and burst addressing
// Assumes: pins are sampled on clk through two flops; burst logic on link_clk
// Notes: each asynchronous operation is closed by a rise of ce_n
`timescale 1ns/1ps
`default_nettype none
module psc_cfg_regs import psc_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic register_enable_pin,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic address_valid_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  output logic array_sel,
  input wire logic wait_req,
  output logic wait_o,
  output logic wait_oe,
  output logic [COL_W-1:0] burst_col,
  output logic burst_active,
  output logic burst_row_end,
  output logic sync_mode,
  output logic fixed_latency,
  output logic [2:0] latency_code,
  output logic wait_active_high,
  output logic wait_early,
  output logic [1:0] drive_code,
  output logic burst_nowrap,
  output logic [2:0] burst_len_code,
  output logic [DATA_W-1:0] refresh_configuration
);

  // ==========================================
  // state
  typedef struct packed {
    psc_pins_s p1;
    psc_pins_s p2;
    psc_pins_s p3;
    psc_seq_e st;
    logic in_op;
    logic op_wr;
    logic op_regen;
    logic cap;
    logic [ADDR_W-1:0] op_addr;
    logic [DATA_W-1:0] op_data;
    logic [1:0] sel;
    logic [DATA_W-1:0] bus_configuration;
    logic [DATA_W-1:0] refresh_configuration;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
    logic blk;
    logic tgl;
  } psc_main_s;

  typedef struct packed {
    logic r1;
    logic r2;
    logic t1;
    logic t2;
    logic t3;
    logic [DATA_W-1:0] cfg;
    logic wdly;
  } psc_link_s;

  psc_main_s s_q;
  psc_main_s s_d;
  psc_link_s l_q;
  psc_link_s l_d;
  psc_pins_s pin_now;
  psc_pins_s cur;
  psc_pins_s prv;
  logic ce_fall;
  logic ce_rise;
  logic first_rise;
  logic op_end;
  logic top;
  logic [ADDR_W-1:0] eff_addr;
  logic [DATA_W-1:0] eff_data;
  logic eff_wr;
  logic pin_hit;
  logic sw_wr;
  logic wr_en;
  logic [1:0] wr_sel;
  logic [DATA_W-1:0] wval;
  logic rd_en;
  logic [1:0] rd_sel;
  logic [DATA_W-1:0] rdval;
  logic sw_ok;
  logic wsel;
  psc_burst_if bif ();

  function automatic logic [1:0] sw_to_sel(input logic [DATA_W-1:0] d);
    sw_to_sel = SEL_REF;
    if (d == SW_BUS) begin
      sw_to_sel = SEL_BUS;
    end else if (d == SW_ID) begin
      sw_to_sel = SEL_ID;
    end
  endfunction

  // ==========================================
  // operation framing
  assign pin_now = {register_enable_pin, ce_n, we_n, oe_n, address_valid_n, addr, dq_i};
  assign cur = s_q.p2;
  assign prv = s_q.p3;
  assign ce_fall = prv.ce_n && !cur.ce_n;
  assign ce_rise = !prv.ce_n && cur.ce_n;
  assign op_end = s_q.in_op && ce_rise;
  // first rising strobe latches address and data
  assign first_rise = s_q.in_op && !s_q.cap && ((!prv.avalid_n && cur.avalid_n)
    || (!prv.we_n && cur.we_n) || ce_rise);
  assign eff_addr = first_rise ? prv.addr : s_q.op_addr;
  assign eff_data = first_rise ? prv.dq : s_q.op_data;
  assign eff_wr = s_q.op_wr || !prv.we_n;
  assign top = eff_addr == TOP_ADDR;
  assign sw_ok = eff_data == SW_REF || eff_data == SW_BUS || eff_data == SW_ID;

  // ==========================================
  // register writes, both paths side by side
  assign pin_hit = s_q.op_regen && eff_wr;
  assign sw_wr = !s_q.op_regen && top && s_q.st == SQ_WR3 && eff_wr;
  assign wr_en = op_end && (pin_hit || sw_wr);
  assign wr_sel = s_q.op_regen ? eff_addr[SEL_HI:SEL_LO] : s_q.sel;
  assign wval = s_q.op_regen ? eff_addr[DATA_W-1:0] : eff_data;

  // ==========================================
  // register reads
  assign rd_sel = cur.regen ? cur.addr[SEL_HI:SEL_LO] : s_q.sel;
  assign rd_en = s_q.in_op && !cur.oe_n && cur.we_n
    && (cur.regen || (cur.addr == TOP_ADDR && s_q.st == SQ_WR3));

  always_comb begin
    rdval = '0;
    unique case (rd_sel)
      SEL_REF: rdval = s_q.refresh_configuration;
      SEL_BUS: rdval = s_q.bus_configuration;
      SEL_ID: rdval = ID_VALUE;
      default: rdval = '0;
    endcase
  end

  // ==========================================
  // main next state
  always_comb begin
    s_d = s_q;
    s_d.p1 = pin_now;
    s_d.p2 = s_q.p1;
    s_d.p3 = s_q.p2;
    if (ce_fall) begin
      s_d.in_op = 1'b1;
      s_d.op_wr = 1'b0;
      s_d.cap = 1'b0;
      s_d.op_regen = cur.regen;
      s_d.op_addr = cur.addr;
    end else if (s_q.in_op) begin
      if (!cur.we_n) begin
        s_d.op_wr = 1'b1;
      end
      if (!s_q.cap && !cur.avalid_n) begin
        s_d.op_addr = cur.addr;
      end
      if (first_rise) begin
        s_d.cap = 1'b1;
        s_d.op_addr = prv.addr;
        s_d.op_data = prv.dq;
      end
    end
    if (op_end) begin
      s_d.in_op = 1'b0;
      if (s_q.op_regen || !top) begin
        s_d.st = SQ_IDLE;
      end else begin
        unique case (s_q.st)
          SQ_IDLE: s_d.st = eff_wr ? SQ_IDLE : SQ_RD1;
          SQ_RD1: s_d.st = eff_wr ? SQ_IDLE : SQ_RD2;
          SQ_RD2: begin
            if (eff_wr && sw_ok) begin
              s_d.st = SQ_WR3;
              s_d.sel = sw_to_sel(eff_data);
            end else if (eff_wr) begin
              s_d.st = SQ_IDLE;
            end
          end
          SQ_WR3: s_d.st = SQ_IDLE;
          default: s_d.st = SQ_IDLE;
        endcase
      end
    end
    if (wr_en) begin
      unique case (wr_sel)
        SEL_REF: s_d.refresh_configuration = wval;
        SEL_BUS: begin
          s_d.bus_configuration = wval;
          s_d.tgl = !s_q.tgl;
        end
        default: s_d.tgl = s_q.tgl;
      endcase
    end
    s_d.dq_oe = rd_en;
    s_d.dq_o = rdval;
    // keep the top array word out of reach during the third and fourth steps of the sequence
    s_d.blk = cur.regen || (cur.addr == TOP_ADDR
      && (s_q.st == SQ_RD2 || s_q.st == SQ_WR3));
    if (!resetn) begin
      s_d = '0;
      s_d.st = SQ_IDLE;
      s_d.sel = SEL_REF;
      s_d.bus_configuration = BUS_RESET;
      s_d.refresh_configuration = REF_RESET;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // ==========================================
  // link domain: config copy, wait, burst control
  always_comb begin
    l_d = l_q;
    l_d.r1 = resetn;
    l_d.r2 = l_q.r1;
    l_d.t1 = s_q.tgl;
    l_d.t2 = l_q.t1;
    l_d.t3 = l_q.t2;
    l_d.wdly = wait_req;
    // word is held still while the toggle crosses
    if (l_q.t2 != l_q.t3) begin
      l_d.cfg = s_q.bus_configuration;
    end
    if (!l_q.r2) begin
      l_d.t2 = 1'b0;
      l_d.t3 = 1'b0;
      l_d.cfg = BUS_RESET;
      l_d.wdly = 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    l_q <= l_d;
  end

  assign wsel = l_q.cfg[B_WCFG] ? wait_req : l_q.wdly;
  assign wait_o = l_q.cfg[B_WPOL] ? wsel : !wsel;
  assign wait_oe = !ce_n;

  assign bif.start = !ce_n && !address_valid_n && !l_q.cfg[B_MODE];
  assign bif.step = !ce_n && address_valid_n && !wait_req;
  assign bif.nowrap = l_q.cfg[B_NOWRAP];
  assign bif.len_code = l_q.cfg[B_LEN_HI:B_LEN_LO];
  assign bif.start_col = addr[COL_W-1:0];

  psc_burst_gen u_burst (
    .lclk(link_clk),
    .lrstn(l_q.r2),
    .bif(bif)
  );

  // ==========================================
  // outputs
  assign dq_o = s_q.dq_o;
  assign dq_oe = s_q.dq_oe;
  assign array_sel = !s_q.blk;
  assign burst_col = bif.col;
  assign burst_active = bif.active;
  assign burst_row_end = bif.row_end;
  assign sync_mode = !s_q.bus_configuration[B_MODE];
  assign fixed_latency = s_q.bus_configuration[B_FIXED];
  assign latency_code = s_q.bus_configuration[B_LAT_HI:B_LAT_LO];
  assign wait_active_high = s_q.bus_configuration[B_WPOL];
  assign wait_early = s_q.bus_configuration[B_WCFG];
  assign drive_code = s_q.bus_configuration[B_DRV_HI:B_DRV_LO];
  assign burst_nowrap = s_q.bus_configuration[B_NOWRAP];
  assign burst_len_code = s_q.bus_configuration[B_LEN_HI:B_LEN_LO];
  assign refresh_configuration = s_q.refresh_configuration;

  // ==========================================
  // checks
  sequence sq_op3_bus;
    op_end && !s_q.op_regen && top && s_q.st == SQ_RD2 && eff_wr && eff_data == SW_BUS;
  endsequence

  sequence sq_op4_bus;
    op_end && sw_wr && s_q.sel == SEL_BUS;
  endsequence

  a_bus_reset_val: assert property (@(posedge clk) disable iff (!resetn)
    ($past(resetn) == 1'b0) |-> s_q.bus_configuration == BUS_RESET)
    else $error("bus register not at default after reset");

  a_sel_decode: assert property (@(posedge clk) disable iff (!resetn)
    sq_op3_bus |=> (s_q.st == SQ_WR3 && s_q.sel == SEL_BUS))
    else $error("third step did not select the bus register");

  a_sw_write_bcr: assert property (@(posedge clk) disable iff (!resetn)
    sq_op4_bus |=> s_q.bus_configuration == $past(eff_data))
    else $error("software write missed the bus register");

  a_pin_bus_write: assert property (@(posedge clk) disable iff (!resetn)
    (wr_en && s_q.op_regen && wr_sel == SEL_BUS) |=> s_q.bus_configuration == $past(wval))
    else $error("pin write missed the bus register");

  a_id_readonly: assert property (@(posedge clk) disable iff (!resetn)
    (wr_en && wr_sel == SEL_ID)
    |=> ($stable(s_q.bus_configuration) && $stable(s_q.refresh_configuration)))
    else $error("identification write changed a register");

  a_bus_hold: assert property (@(posedge clk) disable iff (!resetn)
    $changed(s_q.bus_configuration) |-> $past(op_end))
    else $error("bus register changed outside an operation end");

  a_read_drive: assert property (@(posedge clk) disable iff (!resetn)
    rd_en |=> (dq_oe && dq_o == $past(rdval)))
    else $error("register read not driven on data lines");

  a_array_guard: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.st == SQ_WR3 && cur.addr == TOP_ADDR) |=> !array_sel)
    else $error("top array word reachable during sequence");

  a_wait_late: assert property (@(posedge link_clk) disable iff (!l_q.r2)
    (!l_q.cfg[B_WCFG] && $stable(l_q.cfg))
    |-> wait_o == (l_q.cfg[B_WPOL] ? $past(wait_req) : !$past(wait_req)))
    else $error("late wait not one cycle behind its request");

endmodule
`default_nettype wire

//--- psc_ctl_model.sv
// Purpose: memory controller model driving the pins of the register bank
// Assumes: asynchronous ops on clk, bursts on link_clk
// Notes: released data lines carry the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module psc_ctl_model import psc_pkg::*; (
  input wire logic clk,
  input wire logic link_clk,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe,
  input wire logic array_sel,
  output logic register_enable_pin,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic address_valid_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_i,
  output logic wait_req
);
  logic asel;
  logic oe_seen;

  initial begin
    register_enable_pin = 1'b0;
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    address_valid_n = 1'b1;
    addr = '0;
    dq_i = 16'h0000;
    wait_req = 1'b0;
  end

  // ==========================================
  // asynchronous operation, closed by ce_n rise
  task automatic async_op(input logic regen, input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd);
    @(posedge clk);
    register_enable_pin <= regen;
    ce_n <= 1'b0;
    address_valid_n <= 1'b0;
    addr <= a;
    we_n <= !wr;
    oe_n <= wr;
    dq_i <= wr ? d : ~dq_i;
    repeat (5) @(posedge clk);
    rd = dq_o;
    oe_seen = dq_oe;
    asel = array_sel;
    we_n <= 1'b1;
    oe_n <= 1'b1;
    address_valid_n <= 1'b1;
    @(posedge clk);
    ce_n <= 1'b1;
    dq_i <= ~dq_i;
    repeat (6) @(posedge clk);
  endtask

  // ==========================================
  // burst on the link clock
  task automatic burst_start(input logic [COL_W-1:0] col);
    @(posedge link_clk);
    register_enable_pin <= 1'b0;
    ce_n <= 1'b0;
    address_valid_n <= 1'b0;
    addr <= {{(ADDR_W-COL_W){1'b0}}, col};
    @(posedge link_clk);
    address_valid_n <= 1'b1;
  endtask

  task automatic set_wait(input logic v);
    @(posedge link_clk);
    wait_req <= v;
  endtask

  task automatic burst_stop();
    @(posedge link_clk);
    ce_n <= 1'b1;
    wait_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench of the configuration register bank
// Assumes: register model kept in integers, burst order in a queue
// Notes: legal field codes are programmed, and also the reserved burst length code 7, which runs as continuous
`timescale 1ns/1ps
`default_nettype none
module tb import psc_pkg::*; ();
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic register_enable_pin, ce_n, we_n, oe_n, address_valid_n, wait_req;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_i, dq_o, refresh_configuration, rd;
  logic dq_oe, array_sel, wait_o, wait_oe, burst_active, burst_row_end;
  logic sync_mode, fixed_latency, wait_active_high, wait_early, burst_nowrap;
  logic [2:0] latency_code, burst_len_code;
  logic [1:0] drive_code;
  logic [COL_W-1:0] burst_col;
  int fails = 0;
  int total_checks = 0;
  int bus_m = 'h9d1f;
  int ref_m = 'h0010;
  int exq[$];

  always #50 clk = ~clk;
  always #80 link_clk = ~link_clk;

  psc_cfg_regs uut (.clk, .resetn, .link_clk, .register_enable_pin, .ce_n, .we_n, .oe_n,
    .address_valid_n, .addr, .dq_i, .dq_o, .dq_oe, .array_sel, .wait_req, .wait_o,
    .wait_oe, .burst_col, .burst_active, .burst_row_end, .sync_mode, .fixed_latency,
    .latency_code, .wait_active_high, .wait_early, .drive_code, .burst_nowrap,
    .burst_len_code, .refresh_configuration);

  psc_ctl_model ctl (.clk, .link_clk, .dq_o, .dq_oe, .array_sel, .register_enable_pin,
    .ce_n, .we_n, .oe_n, .address_valid_n, .addr, .dq_i, .wait_req);

  // ==========================================
  // checking helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic int reg_of(input logic [1:0] sel);
    return sel == SEL_BUS ? bus_m : sel == SEL_REF ? ref_m : sel == SEL_ID ? ID_VALUE : 0;
  endfunction

  function automatic logic [15:0] rnd_bcr(input logic sync);
    logic [2:0] lens [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    return {!sync, 1'($urandom), 3'($urandom_range(6, 2)), 1'($urandom), 1'b0,
            1'($urandom), 2'h0, 2'($urandom_range(2, 0)), 1'($urandom),
            lens[$urandom_range(4, 0)]};
  endfunction

  task automatic chk_bus();
    logic [15:0] b;
    b = bus_m[15:0];
    chk("sync_mode", sync_mode, !b[15]);
    chk("fixed_latency", fixed_latency, b[14]);
    chk("latency_code", latency_code, b[13:11]);
    chk("wait_active_high", wait_active_high, b[10]);
    chk("wait_early", wait_early, b[8]);
    chk("drive_code", drive_code, b[5:4]);
    chk("burst_nowrap", burst_nowrap, b[3]);
    chk("burst_len_code", burst_len_code, b[2:0]);
    chk("refresh", refresh_configuration, ref_m[15:0]);
  endtask

  // ==========================================
  // register access by pin and by sequence
  task automatic pin_wr(input logic [1:0] sel, input logic [15:0] v);
    ctl.async_op(1'b1, 1'b1, {2'h0, sel, 2'h0, v}, 16'h0000, rd);
    chk("pin_array_sel", ctl.asel, 0);
    if (sel == SEL_BUS) bus_m = v;
    if (sel == SEL_REF) ref_m = v;
    chk_bus();
  endtask

  task automatic pin_rd(input logic [1:0] sel);
    ctl.async_op(1'b1, 1'b0, {2'h0, sel, 18'h2aaaa}, 16'h0000, rd);
    chk("pin_read", rd, reg_of(sel));
    chk("pin_read_oe", ctl.oe_seen, 1);
  endtask

  task automatic sw_acc(input logic wr, input logic [15:0] sel, input logic [15:0] v);
    logic [1:0] ps;
    ps = sel == SW_BUS ? SEL_BUS : sel == SW_REF ? SEL_REF : SEL_ID;
    ctl.async_op(1'b0, 1'b0, TOP_ADDR, 16'h0000, rd);
    ctl.async_op(1'b0, 1'b0, TOP_ADDR, 16'h0000, rd);
    ctl.async_op(1'b0, 1'b1, TOP_ADDR, sel, rd);
    ctl.async_op(1'b0, wr, TOP_ADDR, v, rd);
    chk("seq_array_sel", ctl.asel, 0);
    if (!wr) chk("sw_read", rd, reg_of(ps));
    if (wr && sel == SW_BUS) bus_m = v;
    if (wr && sel == SW_REF) ref_m = v;
    chk_bus();
  endtask

  // ==========================================
  // burst order against the queue model
  task automatic burst_run(input logic nowrap, input logic [2:0] code, input logic [7:0] start);
    logic [15:0] v;
    int n;
    v = rnd_bcr(1'b1);
    v[3] = nowrap;
    v[2:0] = code;
    pin_wr(SEL_BUS, v);
    repeat (4) @(posedge link_clk);
    n = (code >= 1 && code <= 4) ? (4 << (code - 1)) : 256;
    exq.delete();
    for (int i = 0; i < n; i++) begin
      if (nowrap || n == 256) begin
        if (start + i <= 255) exq.push_back(start + i);
      end else begin
        exq.push_back((start & ~(n - 1)) + ((start + i) % n));
      end
    end
    ctl.burst_start(start);
    foreach (exq[i]) begin
      #1;
      chk("burst_col", burst_col, exq[i]);
      chk("burst_row_end", burst_row_end, (nowrap || n == 256) && exq[i] == 255);
      @(posedge link_clk);
    end
    #1;
    chk("burst_done", burst_active, 0);
    ctl.set_wait(1'b1);
    #1;
    chk("wait_lead", wait_o, v[8] ? v[10] : !v[10]);
    chk("wait_oe", wait_oe, 1);
    @(posedge link_clk);
    #1;
    chk("wait_level", wait_o, v[10]);
    ctl.burst_stop();
    #1;
    chk("wait_oe_idle", wait_oe, 0);
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    void'($urandom(32'he0e19f73));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk_bus();
    for (int i = 0; i < 6; i++) begin
      pin_wr(SEL_BUS, rnd_bcr(1'b0));
      pin_rd(SEL_BUS);
    end
    pin_wr(SEL_REF, {8'h00, 8'($urandom)});
    pin_rd(SEL_REF);
    pin_wr(SEL_ID, 16'h1234);
    pin_rd(SEL_ID);
    pin_rd(2'h3);
    sw_acc(1'b1, SW_BUS, rnd_bcr(1'b0));
    sw_acc(1'b1, SW_REF, {8'h00, 8'($urandom)});
    sw_acc(1'b1, SW_ID, 16'h5555);
    for (int i = 0; i < 3; i++) sw_acc(1'b0, 16'(i), 16'h0000);
    burst_run(1'b0, LEN_4, 8'h06);
    burst_run(1'b1, LEN_4, 8'hfe);
    burst_run(1'b1, 3'h7, 8'hfa);
    for (int i = 0; i < 4; i++) burst_run(1'($urandom), 3'(i + 1), 8'($urandom));
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
